// ---- hdl/glcs_regs.sv ----
/*
 * GPIO output/input level registers and analog channel scan selection.
 * Assumes a same-clock register port from the serial decoder, pin inputs
 * from outside the clock domain, and pin/direction masks from a sibling block.
 * Limitation: level, mask and pin buses are eight bits wide.
 */
`timescale 1ns/1ps
`default_nettype none

module glcs_regs
	import glcs_pkg::*;
#(
	parameter int CHANNELS = 8
)
(
	input wire logic clk_in, // 250 MHz clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic ce_in, // Clock enable, freezes state when low
	input wire glcs_bus_req_type bus_in, // Register access request
	output logic [7:0] rdata_out, // Read data, registered
	output logic rvalid_out, // Read data valid, one cycle
	input wire logic [CHANNELS-1:0] pin_level_in, // Raw channel pin levels
	input wire logic [CHANNELS-1:0] pin_gpio_mask_in, // 1 = channel is GPIO
	input wire logic [CHANNELS-1:0] pin_dir_mask_in, // 1 = GPIO is output
	output logic [CHANNELS-1:0] digital_output_pin_out, // Pin output level
	output logic [CHANNELS-1:0] digital_output_pin_oe_out, // Pin output enable
	input wire logic conv_done_in, // Converter took the current channel
	output glcs_conv_sel_type conv_sel_out, // Channel offered to converter
	output logic scan_active_out // Auto sequence running
);

	glcs_state_type st_r;
	glcs_state_type st_nxt;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Next enabled channel above cur, wrapping; cur itself if alone
	// Eight probes cover the whole ring, so the search stays bounded
	function automatic logic [2:0] next_enabled(input logic [7:0] mask, input logic [2:0] cur);
		logic [2:0] res;
		logic [2:0] idx;
		logic found;
		res = cur;
		found = 1'b0;
		for (int i = 1; i <= 8; i++)
		begin
			idx = 3'(int'(cur) + i);
			if (!found && mask[idx])
			begin
				res = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// Lowest enabled channel
	function automatic logic [2:0] first_enabled(input logic [7:0] mask);
		return next_enabled(mask, 3'h7);
	endfunction

	function automatic logic addr_hit(input glcs_bus_req_type req, input logic [7:0] off);
		return req.addr == off;
	endfunction

	// Empty mask keeps the sequencer idle even with run set
	wire logic auto_mode = (st_r.scan_select == GLCS_SCAN_AUTO);
	wire logic running = auto_mode && st_r.scan_run && (st_r.scan_enable_mask != GLCS_ZERO_BYTE);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// Pulse only; a held valid would answer one read twice
		st_nxt.rvalid = 1'b0;

		// ----------------------------------------
		// Pin synchroniser
		// ----------------------------------------
		// Only the second stage is read, so a metastable
		// first stage never reaches the bus
		// two-flop pin sampling
		st_nxt.input_meta = pin_level_in;
		st_nxt.input_level_bits = st_r.input_meta;

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		// Writes to the read-only input level offset fall through
		if (bus_in.write_en)
		begin
			if (addr_hit(bus_in, GLCS_OUTPUT_LEVEL_OFF))
				st_nxt.output_level_bits = bus_in.wdata;
			if (addr_hit(bus_in, GLCS_SCAN_CONTROL_OFF))
			begin
				st_nxt.scan_run = bus_in.wdata[GLCS_SCAN_RUN_BIT];
				st_nxt.scan_select = glcs_scan_select_type'(bus_in.wdata[GLCS_SCAN_SEL_LSB +: 2]);
			end
			if (addr_hit(bus_in, GLCS_MANUAL_PICK_OFF))
				st_nxt.manual_channel_id = bus_in.wdata[GLCS_CHID_MSB:0];
			if (addr_hit(bus_in, GLCS_SCAN_ENABLE_OFF))
				st_nxt.scan_enable_mask = bus_in.wdata;
		end

		// ----------------------------------------
		// Auto sequencer
		// ----------------------------------------
		// A channel disabled under the sequencer is left at once,
		// without waiting for the converter, so no stale pick stands
		// ascending step, restart at lowest on stop
		if (running)
		begin
			if (!st_r.scan_enable_mask[st_r.auto_channel])
				st_nxt.auto_channel = next_enabled(st_r.scan_enable_mask, st_r.auto_channel);
			else if (conv_done_in)
				st_nxt.auto_channel = next_enabled(st_r.scan_enable_mask, st_r.auto_channel);
		end
		else
			st_nxt.auto_channel = first_enabled(st_r.scan_enable_mask);

		// ----------------------------------------
		// Read mux
		// ----------------------------------------
		// Reads see the state before a write in the same cycle
		if (bus_in.read_en)
		begin
			st_nxt.rvalid = 1'b1;
			unique case (bus_in.addr)
				GLCS_OUTPUT_LEVEL_OFF: st_nxt.rdata = st_r.output_level_bits;
				GLCS_INPUT_LEVEL_OFF: st_nxt.rdata = st_r.input_level_bits;
				GLCS_SCAN_CONTROL_OFF: st_nxt.rdata = {3'h0, st_r.scan_run, 2'h0, st_r.scan_select};
				GLCS_MANUAL_PICK_OFF: st_nxt.rdata = {4'h0, st_r.manual_channel_id};
				GLCS_SCAN_ENABLE_OFF: st_nxt.rdata = st_r.scan_enable_mask;
				default: st_nxt.rdata = GLCS_ZERO_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			st_r <= '0;
			// Named fields restated so the reset modes stay visible
			st_r.scan_select <= GLCS_SCAN_MANUAL;
			st_r.manual_channel_id <= GLCS_CHID_RESET;
			st_r.output_level_bits <= GLCS_RESET_VALUE;
		end
		else if (ce_in)
			st_r <= st_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_out = st_r.rdata;
	assign rvalid_out = st_r.rvalid;
	assign scan_active_out = running;

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Masks come from the sibling pin block on this clock,
	// so they are used without synchronising

	assign digital_output_pin_oe_out = pin_gpio_mask_in & pin_dir_mask_in;
	assign digital_output_pin_out = st_r.output_level_bits & digital_output_pin_oe_out;

	// ----------------------------------------
	// Converter select
	// ----------------------------------------
	// Reserved codes offer no channel; the converter must idle

	always_comb
	begin
		conv_sel_out = '0;
		unique case (st_r.scan_select)
			GLCS_SCAN_MANUAL:
			begin
				conv_sel_out.reserved_code = st_r.manual_channel_id[GLCS_CHID_MSB];
				conv_sel_out.valid = !st_r.manual_channel_id[GLCS_CHID_MSB];
				conv_sel_out.channel = st_r.manual_channel_id[2:0];
			end
			GLCS_SCAN_AUTO:
			begin
				conv_sel_out.valid = running;
				conv_sel_out.channel = st_r.auto_channel;
			end
			// On-the-fly channel comes with each frame, outside this bank
			GLCS_SCAN_ON_THE_FLY: conv_sel_out.valid = 1'b0;
			GLCS_SCAN_RESERVED: conv_sel_out.reserved_code = 1'b1;
		endcase
	end

endmodule

`default_nettype wire

// ---- hdl/glcs_pkg.sv ----
/*
 * Package for the GPIO level and channel scan register bank.
 * Assumes an 8-bit register access port driven by the serial interface decoder.
 */
package glcs_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] GLCS_OUTPUT_LEVEL_OFF = 8'h0B;
	localparam logic [7:0] GLCS_INPUT_LEVEL_OFF = 8'h0D;
	localparam logic [7:0] GLCS_SCAN_CONTROL_OFF = 8'h10;
	localparam logic [7:0] GLCS_MANUAL_PICK_OFF = 8'h11;
	localparam logic [7:0] GLCS_SCAN_ENABLE_OFF = 8'h12;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int GLCS_SCAN_RUN_BIT = 4;
	localparam int GLCS_SCAN_SEL_LSB = 0;
	localparam int GLCS_CHID_MSB = 3;
	localparam logic [7:0] GLCS_RESET_VALUE = 8'h00;
	localparam logic [3:0] GLCS_CHID_RESET = 4'h0;
	localparam logic [7:0] GLCS_ZERO_BYTE = 8'h00;

	typedef enum logic [1:0]
	{
		GLCS_SCAN_MANUAL = 2'h0,
		GLCS_SCAN_AUTO = 2'h1,
		GLCS_SCAN_ON_THE_FLY = 2'h2,
		GLCS_SCAN_RESERVED = 2'h3
	} glcs_scan_select_type;

	// Register write and read port
	typedef struct packed
	{
		logic write_en;
		logic read_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} glcs_bus_req_type;

	// Channel selection offered to the converter
	typedef struct packed
	{
		logic valid;
		logic [2:0] channel;
		logic reserved_code;
	} glcs_conv_sel_type;

	typedef struct packed
	{
		logic [7:0] output_level_bits;
		logic [7:0] input_meta;
		logic [7:0] input_level_bits;
		logic scan_run;
		glcs_scan_select_type scan_select;
		logic [3:0] manual_channel_id;
		logic [7:0] scan_enable_mask;
		logic [2:0] auto_channel;
		logic [7:0] rdata;
		logic rvalid;
	} glcs_state_type;

endpackage

// ---- tb/glcs_host_model.sv ----
/* Host model for the register port.
   Assumes the shared clock; drives at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module glcs_host_model
	import glcs_pkg::*;
(
	input wire logic clk_in, // Clock
	output var glcs_bus_req_type bus_out // Register request
);
	initial bus_out = '0;
	// Idle shows inverted data, never a stale match
	task acc(input logic w, input logic [7:0] a, d);
		@(negedge clk_in);
		bus_out = '{w, !w, a, d};
		@(negedge clk_in);
		bus_out = '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ---- tb/glcs_regs_properties.sv ----
/* Checker for the register bank.
   Assumes bind onto the design's ports. */
`timescale 1ns/1ps
`default_nettype none
module glcs_regs_chk
	import glcs_pkg::*;
#(parameter int CHANNELS = 8)
(
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic ce_in, // Enable
	input wire glcs_bus_req_type bus_in, // Request
	input wire logic [7:0] rdata_out, // Read data
	input wire logic rvalid_out, // Read valid
	input wire logic [CHANNELS-1:0] pin_gpio_mask_in, // GPIO mask
	input wire logic [CHANNELS-1:0] pin_dir_mask_in, // Direction
	input wire logic [CHANNELS-1:0] digital_output_pin_out, // Pins
	input wire logic [CHANNELS-1:0] digital_output_pin_oe_out, // Enables
	input wire glcs_conv_sel_type conv_sel_out, // Channel
	input wire logic scan_active_out // Running
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_read_answer: assert property (ce_in && bus_in.read_en |=> rvalid_out)
		else $error("read not answered");
	a_no_spurious: assert property (ce_in && !bus_in.read_en |=> !rvalid_out)
		else $error("unrequested read valid");
	a_freeze_read: assert property (!ce_in |=> $stable(rvalid_out) && $stable(rdata_out))
		else $error("read outputs moved while frozen");
	a_oe_masks: assert property (digital_output_pin_oe_out == (pin_gpio_mask_in & pin_dir_mask_in))
		else $error("output enable wrong");
	a_pin_gated: assert property ((digital_output_pin_out & ~digital_output_pin_oe_out) == 0)
		else $error("pin driven while disabled");
	a_level_write: assert property (
		ce_in && bus_in.write_en && bus_in.addr == GLCS_OUTPUT_LEVEL_OFF
		|=> digital_output_pin_out == ($past(bus_in.wdata) & digital_output_pin_oe_out))
		else $error("output level not applied");
	a_ctl_reserved: assert property (
		rvalid_out && $past(bus_in.addr) == GLCS_SCAN_CONTROL_OFF
		|-> rdata_out[7:5] == 0 && rdata_out[3:2] == 0)
		else $error("scan control reserved set");
	a_chid_reserved: assert property (
		rvalid_out && $past(bus_in.addr) == GLCS_MANUAL_PICK_OFF
		|-> rdata_out[7:4] == 0)
		else $error("channel pick reserved set");
	a_active_valid: assert property (scan_active_out |-> conv_sel_out.valid && !conv_sel_out.reserved_code)
		else $error("active scan offers no channel");
endmodule
bind glcs_regs glcs_regs_chk #(.CHANNELS(CHANNELS)) chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Self-checking bench for the register bank.
   Assumes the host model issues all register traffic. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import glcs_pkg::*;
;
	logic clk_in = 0, rst_in = 1, ce_in = 1, conv_done_in = 0, rvalid_out, scan_active_out;
	logic [7:0] pin_level_in = '0, gm = '0, dm = '0, v, rdata_out, pin_o, pin_oe;
	logic [7:0] offs [5] = '{8'h0B, 8'h0D, 8'h10, 8'h11, 8'h12};
	logic [7:0] msk [5] = '{8'hFF, 8'h00, 8'h13, 8'h0F, 8'hFF};
	logic [2:0] exp_ch [4] = '{3'h2, 3'h5, 3'h7, 3'h2};
	logic [7:0] q [$];
	int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'hDC64B12D;
	glcs_bus_req_type bus;
	glcs_conv_sel_type sel;
	always #2 clk_in = ~clk_in;
	glcs_host_model host (.clk_in(clk_in), .bus_out(bus));
	glcs_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus),
		.rdata_out(rdata_out), .rvalid_out(rvalid_out), .pin_level_in(pin_level_in),
		.pin_gpio_mask_in(gm), .pin_dir_mask_in(dm), .digital_output_pin_out(pin_o),
		.digital_output_pin_oe_out(pin_oe), .conv_done_in(conv_done_in),
		.conv_sel_out(sel), .scan_active_out(scan_active_out));
	task chk(input string nm, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task rd(input logic [7:0] a, e);
		q.push_back(e);
		host.acc(1'b0, a, 8'h00);
	endtask
	task md(input logic [7:0] c, i, input logic ev, er);
		host.acc(1'b1, 8'h10, c);
		host.acc(1'b1, 8'h11, i);
		if (c != 8'h03) chk("valid", sel.valid, ev);
		chk("rsv", sel.reserved_code, er);
		if (ev) chk("ch", sel.channel, i[2:0]);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge clk_in)
	begin
		cyc++;
		if (rvalid_out === 1'b1) chk("rdata", rdata_out, q.pop_front());
		if (cyc == 5000)
		begin
			error_cnt++;
			close_out();
		end
	end
	initial
	begin
		repeat (12) @(negedge clk_in);
		rst_in = 0;
		foreach (offs[i]) rd(offs[i], 8'h00);
		repeat (4) foreach (offs[i])
		begin
			v = $random(seed);
			host.acc(1'b1, offs[i], v);
			rd(offs[i], v & msk[i]);
		end
		rd(8'h20, 8'h00);
		@(negedge clk_in);
		ce_in = 0;
		host.acc(1'b1, 8'h12, ~v);
		ce_in = 1;
		rd(8'h12, v);
		$display("register test done");
		repeat (8)
		begin
			gm = $random(seed);
			dm = $random(seed);
			pin_level_in = $random(seed);
			v = $random(seed);
			host.acc(1'b1, 8'h0B, v);
			chk("oe", pin_oe, gm & dm);
			chk("pin", pin_o, v & gm & dm);
			repeat (2) @(negedge clk_in);
			rd(8'h0D, pin_level_in);
		end
		$display("pin test done");
		// Analog channels only for conversion
		gm = '0;
		for (int k = 0; k < 8; k++) md(8'h00, k[7:0], 1'b1, 1'b0);
		md(8'h00, 8'h09, 1'b0, 1'b1);
		md(8'h02, 8'h03, 1'b0, 1'b0);
		md(8'h03, 8'h00, 1'b0, 1'b1);
		host.acc(1'b1, 8'h12, 8'hA4);
		host.acc(1'b1, 8'h10, 8'h11);
		foreach (exp_ch[i])
		begin
			chk("act", scan_active_out, 1'b1);
			chk("auto", sel.channel, exp_ch[i]);
			@(negedge clk_in) conv_done_in = 1;
			@(negedge clk_in) conv_done_in = 0;
		end
		host.acc(1'b1, 8'h12, 8'h81);
		@(negedge clk_in);
		chk("skip", sel.channel, 3'h7);
		host.acc(1'b1, 8'h10, 8'h01);
		chk("stop", scan_active_out, 1'b0);
		chk("stopv", sel.valid, 1'b0);
		@(negedge clk_in);
		chk("park", sel.channel, 3'h0);
		host.acc(1'b1, 8'h10, 8'h10);
		chk("manual", scan_active_out, 1'b0);
		$display("scan test done");
		rst_in = 1;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		foreach (offs[i]) rd(offs[i], i == 1 ? pin_level_in : 8'h00);
		repeat (3) @(negedge clk_in);
		chk("queue", q.size(), 8'h00);
		$display("reset test done");
		close_out();
	end
endmodule
`default_nettype wire
